// ===== bench/cid_checker.sv
`timescale 1ns/1ps
module cid_checker
	import cid_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	// Link signals
	input  wire logic [15:0] word,
	input  wire logic        valid,
	input  wire logic        ready,
	input  wire logic        busy
);
	logic [15:0] op_r;
	logic [7:0]  cnt_r;
	wire         take = valid && ready && !busy;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// An opcode taken while idle names the busy stretch after it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) op_r <= RST_WORD;
		else if (take) op_r <= word;
	end
	// Busy length; too long to unroll, so it is counted
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) cnt_r <= 8'h00;
		else cnt_r <= busy ? cnt_r + 8'h01 : 8'h00;
	end
	scale_time_a: assert property ($fell(busy) && (op_r & ~16'h0080) == OP_SCALE
		|-> cnt_r == SCALE_CYC - 1) else $error("scale time wrong");
	search_time_a: assert property ($fell(busy) && op_r[11:0] == OP_SEARCH_LO
		|-> cnt_r == SEARCH_CYC - 1) else $error("search time wrong");
	stack_time_a: assert property ($fell(busy) && op_r == OP_STACK
		|-> cnt_r == STACK_CYC - 1) else $error("stack time wrong");
	view_time_a: assert property ($fell(busy) && op_r == OP_VIEWPORT
		|-> cnt_r == VIEW_CYC - 1) else $error("viewport time wrong");
	pos_time_a: assert property ($fell(busy) && op_r == OP_POSITION
		|-> cnt_r == POS_CYC - 1) else $error("position time wrong");
	busy_rise_a: assert property (take && (word == OP_STACK || word == OP_VIEWPORT)
		|=> busy) else $error("busy late");
	ready_idle_a: assert property ($fell(busy) |-> ready) else $error("ready low");
	word_hold_a: assert property (valid && !ready |=> valid && $stable(word))
		else $error("word dropped");
	cover property ($fell(busy) && op_r == OP_STACK);
	cover property ($fell(busy) && op_r == OP_VIEWPORT);
	cover property ($fell(busy) && op_r == 16'h00A9);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cid_pkg::*;
	logic        core_clk_i  = 1'b0;
	logic        arst_n_i    = 1'b0;
	logic [15:0] usr_word_i  = 16'h0000;
	logic [15:0] draw_op_i   = 16'h0000;
	logic        usr_valid_i = 1'b0;
	logic        stk_push_i  = 1'b0;
	logic        stk_pop_i   = 1'b0;
	logic        pick_set_i  = 1'b0;
	logic        pick_val_i  = 1'b1;
	logic        usr_ready_o, dev_busy_o, masked_write_o, pick_enable_o, stack_overflow_o;
	logic        x_scale_en_o, y_scale_en_o;
	logic [5:0]  device_position_o;
	logic [3:0]  search_color_o, fill_boundary_o, copy_match_color_o;
	logic [15:0] x_scale_o, y_scale_o, diagonal_length_modifier_o;
	logic [11:0] stack_x_o, stack_start_o, stack_terminate_o, stack_ptr_o;
	logic [11:0] view_x_o, view_y_o, pen_x_o, pen_y_o;
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc = 0;
	cid_link_if lnk ();
	cid_host cid_host_i (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .usr_word_i(usr_word_i),
		.usr_valid_i(usr_valid_i), .usr_ready_o(usr_ready_o), .dev_busy_o(dev_busy_o),
		.link(lnk));
	cid_dev cid_dev_i (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(lnk), .stk_push_i(stk_push_i),
		.stk_pop_i(stk_pop_i), .draw_op_i(draw_op_i), .masked_write_o(masked_write_o),
		.pick_enable_o(pick_enable_o), .device_position_o(device_position_o),
		.search_color_o(search_color_o), .fill_boundary_o(fill_boundary_o),
		.copy_match_color_o(copy_match_color_o), .x_scale_o(x_scale_o), .y_scale_o(y_scale_o),
		.x_scale_en_o(x_scale_en_o), .y_scale_en_o(y_scale_en_o),
		.diagonal_length_modifier_o(diagonal_length_modifier_o), .stack_x_o(stack_x_o),
		.stack_start_o(stack_start_o), .stack_terminate_o(stack_terminate_o),
		.stack_ptr_o(stack_ptr_o), .stack_overflow_o(stack_overflow_o), .view_x_o(view_x_o),
		.view_y_o(view_y_o), .pen_x_o(pen_x_o), .pen_y_o(pen_y_o), .pick_set_i(pick_set_i),
		.pick_val_i(pick_val_i));
	cid_checker cid_checker_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .word(lnk.word),
		.valid(lnk.valid), .ready(lnk.ready), .busy(lnk.busy));
	// Clock, 4 ns period
	initial begin
		forever #2 core_clk_i = ~core_clk_i;
	end
	// Hang guard; the whole run needs well under this
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			final_report;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Offer one word; held until an edge sees ready high
	task automatic send(input logic [15:0] w);
		@(posedge core_clk_i);
		usr_word_i <= w;
		usr_valid_i <= 1'b1;
		@(negedge core_clk_i);
		while (!usr_ready_o) @(negedge core_clk_i);
	endtask
	// Last word goes on this edge, then wait out the busy stretch
	task automatic done;
		int n;
		n = 0;
		@(posedge core_clk_i);
		usr_valid_i <= 1'b0;
		while (!dev_busy_o && n < 8) begin
			@(negedge core_clk_i);
			n++;
		end
		while (dev_busy_o) @(negedge core_clk_i);
	endtask
	task automatic strobe(input logic [2:0] s);
		@(posedge core_clk_i);
		{pick_set_i, stk_pop_i, stk_push_i} <= s;
		@(posedge core_clk_i);
		{pick_set_i, stk_pop_i, stk_push_i} <= 3'h0;
		@(negedge core_clk_i);
	endtask
	task automatic mw(input logic [15:0] op, input logic [15:0] exp);
		@(posedge core_clk_i);
		draw_op_i <= op;
		@(negedge core_clk_i);
		chk(masked_write_o, exp);
	endtask
	function automatic logic [3:0] rev(input logic [3:0] n);
		return {n[0], n[1], n[2], n[3]};
	endfunction
	task automatic t_pos_search;
		int p;
		strobe(3'h4);
		chk(pick_enable_o, 16'h0001);
		for (p = 0; p < 4; p++) begin
			send(OP_POSITION);
			send(16'h0040 | 16'(p));
			done;
			chk(device_position_o, 16'(p));
			chk(pick_enable_o, 16'h0000);
			send(16'h0021);
			send(16'hD543);
			done;
			chk(search_color_o, rev(4'(16'hD543 >> (4 * p))));
		end
		chk(fill_boundary_o, rev(4'hD));
		chk(copy_match_color_o, rev(4'hD));
		chk(pen_x_o, 16'h0000);
		send(16'h1021);
		send(16'hFFFF);
		done;
		chk(search_color_o, rev(4'hD));
		mw(OP_LINE, 16'h0001);
		mw(OP_LINE_CUR, 16'h0001);
		mw(16'h0021, 16'h0000);
		send(OP_POSITION);
		send(16'h0003);
		done;
		mw(OP_LINE, 16'h0000);
		$display("pos_search finished");
	endtask
	task automatic t_scale;
		send(16'h00A9);
		send(16'h4000);
		send(16'h6000);
		send(16'h0016);
		done;
		chk(x_scale_o, 16'h4000);
		chk(y_scale_o, 16'h6000);
		chk(diagonal_length_modifier_o, 16'h0016);
		send(OP_SCALE);
		send(16'h0000);
		send(16'h7FFF);
		done;
		chk(x_scale_en_o, 16'h0000);
		chk(y_scale_en_o, 16'h0001);
		chk(y_scale_o, 16'h7FFF);
		chk(diagonal_length_modifier_o, 16'h0016);
		$display("scale finished");
	endtask
	task automatic t_stack;
		send(OP_STACK);
		send(16'h03F0);
		send(16'h0002);
		send(16'h0004);
		// Next opcode is offered while the setup runs, so the host must hold it
		send(OP_POSITION);
		send(16'h0003);
		done;
		chk(stack_x_o, 16'h03F0);
		chk(stack_start_o, 16'h0002);
		chk(stack_terminate_o, 16'h0004);
		chk(stack_ptr_o, 16'h0002);
		chk(pen_y_o, 16'h0000);
		chk(device_position_o, 16'h0003);
		strobe(3'h1);
		chk(stack_ptr_o, 16'h0003);
		strobe(3'h1);
		chk(stack_overflow_o, 16'h0000);
		strobe(3'h1);
		chk(stack_overflow_o, 16'h0001);
		repeat (5) strobe(3'h2);
		chk(stack_ptr_o, 16'h0002);
		chk(stack_overflow_o, 16'h0001);
		// Software setup with a wider region, 0 to 03FC, which also clears the overflow flag
		send(OP_STACK);
		send(16'h03F0);
		send(16'h0000);
		send(16'h03FC);
		done;
		chk(stack_start_o, 16'h0000);
		chk(stack_terminate_o, 16'h03FC);
		chk(stack_ptr_o, 16'h0000);
		chk(stack_overflow_o, 16'h0000);
		$display("stack finished");
	endtask
	task automatic t_view;
		send(OP_VIEWPORT);
		send(16'h01F4);
		send(16'h01F4);
		done;
		chk(view_x_o, 16'h01F4);
		chk(pen_y_o, 16'h01F4);
		send(OP_VIEWPORT);
		send(16'h800A);
		send(16'h0FF6);
		done;
		chk(view_x_o, 16'h01FE);
		chk(view_y_o, 16'h01EA);
		chk(pen_x_o, 16'h01FE);
		chk(pen_y_o, 16'h01EA);
		$display("view finished");
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(negedge core_clk_i);
		t_pos_search;
		t_scale;
		t_stack;
		t_view;
		final_report;
	end
endmodule

// ===== rtl/cid_dev.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// What this block does
// - Bit-wise instruction runs only on group match
// - Low position bits pick operand nibble
// - Position setup always clears picking enable
// - Masked writes only for line instructions
// - Scale loads X,Y; zero disables axis
// - Scale factor is 15-bit, top zero
// - Opcode bit 7 adds diagonal modifier word
// - Scale instruction takes 57 cycles
// - Search nibble MSB is plane 0
// - Search colour feeds fill and copy
// - Search colour 112 cycles, pen unchanged
// - Stack lives in plane 0
// - Host gives word-aligned stack X
// - Stack grows start to terminate, overflow flagged
// - Stack setup 0039, three words, 90 cycles
// - Software reserves large stack region
// - Viewport 0067 resolves relative base, stores it
// - Position setup sets masked write enable
// - Viewport instruction takes 85 cycles
module cid_dev
	import cid_pkg::*;
#(
	parameter int COORD_W = 12
)
(
	// Clock and reset
	input  wire logic               core_clk_i,
	input  wire logic               arst_n_i,
	// Link to host
	cid_link_if.dev                 link,
	// Stack pointer events from the drawing engine
	input  wire logic               stk_push_i,
	input  wire logic               stk_pop_i,
	// Draw unit queries
	input  wire logic [15:0]        draw_op_i,
	output logic                    masked_write_o,
	output logic                    pick_enable_o,
	// Configuration state
	output logic [5:0]              device_position_o,
	output logic [3:0]              search_color_o,
	output logic [3:0]              fill_boundary_o,
	output logic [3:0]              copy_match_color_o,
	output logic [15:0]             x_scale_o,
	output logic [15:0]             y_scale_o,
	output logic                    x_scale_en_o,
	output logic                    y_scale_en_o,
	output logic [15:0]             diagonal_length_modifier_o,
	output logic [COORD_W-1:0]      stack_x_o,
	output logic [COORD_W-1:0]      stack_start_o,
	output logic [COORD_W-1:0]      stack_terminate_o,
	output logic [COORD_W-1:0]      stack_ptr_o,
	output logic                    stack_overflow_o,
	output logic [COORD_W-1:0]      view_x_o,
	output logic [COORD_W-1:0]      view_y_o,
	output logic [COORD_W-1:0]      pen_x_o,
	output logic [COORD_W-1:0]      pen_y_o,
	input  wire logic               pick_set_i,
	input  wire logic               pick_val_i
);
	typedef enum logic [2:0] {
		CID_IDLE, CID_OPND, CID_WAIT
	} cid_state_e;

	cid_state_e        state_r;
	logic [15:0]       op_r;
	logic [1:0]        idx_r;
	logic [1:0]        need_r;
	logic [CNT_W-1:0]  cnt_r;
	logic [15:0]       w0_r;
	logic [15:0]       w1_r;
	logic              me_r;
	logic              take;
	logic [1:0]        need_nxt;
	logic [CNT_W-1:0]  cyc_nxt;
	logic [3:0]        nib;
	logic [3:0]        nib_rev;
	logic              group_hit;

	assign take = link.valid && link.ready;

	// The diagonal-word flag sits inside the low opcode byte, so scale is matched with it masked
	localparam logic [15:0] DIAG_MASK = 16'h0001 << DIAG_BIT;

	// Operand count and run time per opcode
	always_comb begin
		need_nxt = 2'd0;
		cyc_nxt  = CNT_W'(POS_CYC);
		if (link.word == OP_POSITION) begin
			need_nxt = 2'd1;
		end else if ((link.word & ~DIAG_MASK) == OP_SCALE) begin
			need_nxt = link.word[DIAG_BIT] ? 2'd3 : 2'd2;
			cyc_nxt  = CNT_W'(SCALE_CYC);
		end else if (link.word[11:0] == OP_SEARCH_LO) begin
			need_nxt = 2'd1;
			cyc_nxt  = CNT_W'(SEARCH_CYC);
		end else if (link.word == OP_STACK) begin
			need_nxt = 2'd3;
			cyc_nxt  = CNT_W'(STACK_CYC);
		end else if (link.word == OP_VIEWPORT) begin
			need_nxt = 2'd2;
			cyc_nxt  = CNT_W'(VIEW_CYC);
		end
	end

	// Ready only while idle or gathering operands; busy covers the run time
	assign link.ready = (state_r != CID_WAIT);
	assign link.busy  = (state_r != CID_IDLE);

	// Sequencer: opcode, operand words, then the documented run time
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= CID_IDLE;
			op_r    <= RST_WORD;
			idx_r   <= 2'd0;
			need_r  <= 2'd0;
			cnt_r   <= '0;
		end else begin
			unique case (state_r)
				CID_IDLE: begin
					if (take && need_nxt != 2'd0) begin
						op_r    <= link.word;
						need_r  <= need_nxt;
						idx_r   <= 2'd0;
						cnt_r   <= cyc_nxt - CNT_W'(need_nxt) - CNT_W'(1);
						state_r <= CID_OPND;
					end
				end
				CID_OPND: begin
					if (take) begin
						idx_r <= idx_r + 2'd1;
						if (idx_r + 2'd1 == need_r) begin
							state_r <= CID_WAIT;
						end
					end
				end
				CID_WAIT: begin
					cnt_r <= cnt_r - CNT_W'(1);
					if (cnt_r <= CNT_W'(1)) begin
						state_r <= CID_IDLE;
					end
				end
				default: state_r <= CID_IDLE;
			endcase
		end
	end

	// Keep the first two operands for multi-word commands
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w0_r <= RST_WORD;
			w1_r <= RST_WORD;
		end else if (state_r == CID_OPND && take) begin
			if (idx_r == 2'd0) w0_r <= link.word;
			if (idx_r == 2'd1) w1_r <= link.word;
		end
	end

	logic last_opnd;
	assign last_opnd = (state_r == CID_OPND) && take && (idx_r + 2'd1 == need_r);

	// Group match and nibble pick for bit-wise commands
	assign group_hit = (op_r[15:12] == device_position_o[5:2]);
	assign nib = link.word[4*device_position_o[1:0] +: 4];
	assign nib_rev = {nib[0], nib[1], nib[2], nib[3]}; // bit 0 of result is plane 0

	// Position setup: group, masked writes, picking
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			device_position_o <= 6'h00;
			me_r              <= 1'b0;
			pick_enable_o     <= 1'b0;
		end else if (last_opnd && op_r == OP_POSITION) begin
			device_position_o <= link.word[5:0];
			me_r              <= link.word[POS_ME_BIT];
			pick_enable_o     <= 1'b0;
		end else if (pick_set_i) begin
			pick_enable_o     <= pick_val_i;
		end
	end

	// Only the two line commands may use masked writes
	assign masked_write_o = me_r && (draw_op_i == OP_LINE || draw_op_i == OP_LINE_CUR);

	// Search colour, per plane, held until reprogrammed
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			search_color_o <= 4'h0;
		end else if (last_opnd && op_r[11:0] == OP_SEARCH_LO && group_hit) begin
			search_color_o <= nib_rev;
		end
	end
	assign fill_boundary_o    = search_color_o;
	assign copy_match_color_o = search_color_o;

	// Scale factors and optional diagonal modifier
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			x_scale_o                  <= RST_WORD;
			y_scale_o                  <= RST_WORD;
			diagonal_length_modifier_o <= RST_WORD;
		end else if (state_r == CID_OPND && take && (op_r & ~DIAG_MASK) == OP_SCALE) begin
			if (idx_r == 2'd0) x_scale_o <= {1'b0, link.word[14:0]};
			if (idx_r == 2'd1) y_scale_o <= {1'b0, link.word[14:0]};
			if (idx_r == 2'd2) diagonal_length_modifier_o <= link.word;
		end
	end
	assign x_scale_en_o = (x_scale_o != RST_WORD);
	assign y_scale_en_o = (y_scale_o != RST_WORD);

	// Stack bounds and pointer; the stack itself sits in plane 0
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stack_x_o         <= '0;
			stack_start_o     <= '0;
			stack_terminate_o <= '0;
			stack_ptr_o       <= '0;
			stack_overflow_o  <= 1'b0;
		end else if (last_opnd && op_r == OP_STACK) begin
			stack_x_o         <= w0_r[COORD_W-1:0] & ~COORD_W'(15);
			stack_start_o     <= w1_r[COORD_W-1:0];
			stack_terminate_o <= link.word[COORD_W-1:0];
			stack_ptr_o       <= w1_r[COORD_W-1:0];
			stack_overflow_o  <= 1'b0;
		end else if (stk_push_i && !stk_pop_i) begin
			stack_ptr_o <= stack_ptr_o + COORD_W'(1);
			if (stack_ptr_o >= stack_terminate_o) stack_overflow_o <= 1'b1;
		end else if (stk_pop_i && !stk_push_i && stack_ptr_o != stack_start_o) begin
			stack_ptr_o <= stack_ptr_o - COORD_W'(1); // never below start
		end
	end

	// Viewport base: the X operand's relative flag makes both operands add to the pen, pen follows the base
	logic [COORD_W-1:0] base_x;
	logic [COORD_W-1:0] base_y;
	assign base_x = w0_r[ADDR_REL_BIT] ? pen_x_o + w0_r[COORD_W-1:0] : w0_r[COORD_W-1:0];
	assign base_y = w0_r[ADDR_REL_BIT] ? pen_y_o + link.word[COORD_W-1:0]
		: link.word[COORD_W-1:0];
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			view_x_o <= '0;
			view_y_o <= '0;
			pen_x_o  <= '0;
			pen_y_o  <= '0;
		end else if (last_opnd && op_r == OP_VIEWPORT) begin
			view_x_o <= base_x;
			view_y_o <= base_y;
			pen_x_o  <= base_x;
			pen_y_o  <= base_y;
		end
	end
endmodule

// ===== rtl/cid_host.sv
`timescale 1ns/1ps
// Host end: pushes user words onto the link one at a time
module cid_host
	import cid_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	// User side
	input  wire logic [15:0] usr_word_i,
	input  wire logic        usr_valid_i,
	output logic             usr_ready_o,
	output logic             dev_busy_o,
	// Link
	cid_link_if.host         link
);
	logic [15:0] word_r;
	logic        valid_r;

	// Hold a word until the device accepts it; one word in flight only
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_r  <= RST_WORD;
			valid_r <= 1'b0;
		end else if (usr_valid_i && usr_ready_o) begin
			word_r  <= usr_word_i; // caller supplies zeroed bits
			valid_r <= 1'b1;
		end else if (link.ready) begin
			valid_r <= 1'b0;
		end
	end

	// Accept a new user word once the link slot is free or draining
	assign usr_ready_o = !valid_r || link.ready;
	assign dev_busy_o  = link.busy;
	assign link.word   = word_r;
	assign link.valid  = valid_r;
endmodule

// ===== rtl/cid_link_if.sv
`timescale 1ns/1ps
interface cid_link_if;
	logic [15:0] word;
	logic        valid;
	logic        ready;
	logic        busy;
	modport dev  (input word, input valid, output ready, output busy);
	modport host (output word, output valid, input ready, input busy);
endinterface

// ===== rtl/cid_pkg.sv
package cid_pkg;
	// Opcode words
	localparam logic [15:0] OP_POSITION  = 16'h0038;
	localparam logic [15:0] OP_SCALE     = 16'h0029;
	localparam logic [15:0] OP_STACK     = 16'h0039;
	localparam logic [15:0] OP_VIEWPORT  = 16'h0067;
	localparam logic [11:0] OP_SEARCH_LO = 12'h021;
	localparam logic [11:0] OP_DRAW_LO   = 12'h000;
	localparam logic [15:0] OP_LINE      = 16'h0002;
	localparam logic [15:0] OP_LINE_CUR  = 16'h0003;
	localparam int          DIAG_BIT     = 7;
	// Position word fields
	localparam int          POS_ME_BIT   = 6;
	// Operand address word fields
	localparam int          ADDR_REL_BIT = 15;
	localparam logic [15:0] ADDR_MASK    = 16'h0FFF;
	// Execution times in system clock cycles
	localparam int          SCALE_CYC    = 57;
	localparam int          SEARCH_CYC   = 112;
	localparam int          STACK_CYC    = 90;
	localparam int          VIEW_CYC     = 85;
	localparam int          POS_CYC      = 36;
	localparam int          CNT_W        = 7;
	// Reset values
	localparam logic [15:0] RST_WORD     = 16'h0000;
endpackage
